// >>> src/olc_pkg.sv
// Constants, state types and the reset image of the output level control block.
package olc_pkg;

  // ----------------------------------------------------------------------
  // Register map and reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] OLC_REG_CTRL1  = 8'h00;
  localparam logic [7:0] OLC_REG_CTRL2  = 8'h01;
  localparam logic [7:0] OLC_REG_STATUS = 8'h02;
  localparam logic [7:0] OLC_CTRL1_RST  = 8'h08;
  localparam logic [7:0] OLC_CTRL2_RST  = 8'h09;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int OLC_SRC_BIT  = 7;
  localparam int OLC_CODE_MSB = 4;
  localparam int OLC_CODE_LSB = 1;
  localparam int OLC_EN_BIT   = 3;

  // ----------------------------------------------------------------------
  // Slave addresses and the address-select pin codes
  // ----------------------------------------------------------------------
  localparam logic [1:0] OLC_ASEL_VCC   = 2'h0;
  localparam logic [1:0] OLC_ASEL_FLOAT = 2'h1;
  localparam logic [1:0] OLC_ASEL_GND   = 2'h2;
  localparam logic [6:0] OLC_ADDR_VCC   = 7'h08;
  localparam logic [6:0] OLC_ADDR_FLOAT = 7'h09;
  localparam logic [6:0] OLC_ADDR_GND   = 7'h10;
  localparam logic [6:0] OLC_ADDR_DIV   = 7'h11;

  // ----------------------------------------------------------------------
  // Output levels in units of 0.1 V and the voltage code limits
  // ----------------------------------------------------------------------
  localparam logic [7:0] OLC_LVL_OFF  = 8'h00;
  localparam logic [7:0] OLC_LVL_134  = 8'h86;
  localparam logic [7:0] OLC_LVL_146  = 8'h92;
  localparam logic [7:0] OLC_LVL_182  = 8'hb6;
  localparam logic [7:0] OLC_LVL_194  = 8'hc2;
  localparam logic [7:0] OLC_LVL_200  = 8'hc8;
  localparam logic [7:0] OLC_LVL_BASE = 8'h6e;
  localparam logic [7:0] OLC_LVL_STEP = 8'h06;
  localparam logic [3:0] OLC_CODE_LIN = 4'hc;
  localparam logic [3:0] OLC_CODE_194 = 4'hd;

  // Bits in one serial byte.
  localparam logic [3:0] OLC_BYTE_BITS = 4'h8;

  // ----------------------------------------------------------------------
  // Serial slave states and the module state image
  // ----------------------------------------------------------------------
  typedef enum logic [8:0] {
    OLC_IDLE      = 9'h001,
    OLC_ADDR      = 9'h002,
    OLC_ADDR_ACK  = 9'h004,
    OLC_REG       = 9'h008,
    OLC_REG_ACK   = 9'h010,
    OLC_WDATA     = 9'h020,
    OLC_WDATA_ACK = 9'h040,
    OLC_RDATA     = 9'h080,
    OLC_RDATA_ACK = 9'h100
  } olc_fsm_t;

  typedef struct packed {
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic [2:0] en_s;
    logic [2:0] step_s;
    logic [5:0] asel_s;
    logic       scl_f;
    logic       sda_f;
    logic       en_f;
    logic       step_f;
    logic [1:0] asel_f;
    olc_fsm_t   st;
    logic [3:0] bitcnt;
    logic [7:0] shift;
    logic [7:0] ptr;
    logic       rw;
    logic       sda_oe;
    logic [7:0] ctrl1;
    logic [7:0] ctrl2;
    logic [7:0] level;
  } olc_state_t;

  localparam olc_state_t OLC_STATE_RST = '{
    scl_s: 3'h7, sda_s: 3'h7, scl_f: 1'b1, sda_f: 1'b1, st: OLC_IDLE,
    ctrl1: OLC_CTRL1_RST, ctrl2: OLC_CTRL2_RST, default: '0};

endpackage

// >>> src/olc_top.sv
// Serial slave interface and output level selection of the supply regulator.

module olc_top
  import olc_pkg::*;
(
  // Clock and reset.
  input  wire logic       sys_clk_in,
  input  wire logic       rst_in,
  // Two-wire bus pins.
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_out,
  // Level selection and address-select pins.
  input  wire logic       en_pin_in,
  input  wire logic       level_step_pin_in,
  input  wire logic [1:0] addr_sel_in,
  // Selected output level in 0.1 V units.
  output logic [7:0]      regulated_output_level_out
);

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------

  // Maps the address-select pin state to the slave address.
  function automatic logic [6:0] olc_slave_addr(input logic [1:0] asel);
    if (asel == OLC_ASEL_VCC) begin
      return OLC_ADDR_VCC;
    end else if (asel == OLC_ASEL_FLOAT) begin
      return OLC_ADDR_FLOAT;
    end else if (asel == OLC_ASEL_GND) begin
      return OLC_ADDR_GND;
    end else begin
      return OLC_ADDR_DIV;
    end
  endfunction

  // Chooses the output level from the active source.
  function automatic logic [7:0] olc_level(input logic src, input logic reg_en,
                                           input logic pin_en, input logic pin_scl,
                                           input logic pin_step, input logic [3:0] code);
    if (src) begin
      if (!reg_en) begin
        return OLC_LVL_OFF;
      end else if (code <= OLC_CODE_LIN) begin
        return 8'(OLC_LVL_BASE + OLC_LVL_STEP * {4'h0, code});
      end else if (code == OLC_CODE_194) begin
        return OLC_LVL_194;
      end else begin
        return OLC_LVL_200;
      end
    end else if (!pin_en) begin
      return OLC_LVL_OFF;
    end else begin
      case ({pin_scl, pin_step})
        2'b11:   return OLC_LVL_194;
        2'b10:   return OLC_LVL_146;
        2'b01:   return OLC_LVL_182;
        default: return OLC_LVL_134;
      endcase
    end
  endfunction

  // Returns the register byte seen by a bus read; unmapped offsets read zero.
  function automatic logic [7:0] olc_read(input logic [7:0] p, input logic [7:0] c1,
                                          input logic [7:0] c2, input logic [7:0] lvl);
    if (p == OLC_REG_CTRL1) begin
      return c1;
    end else if (p == OLC_REG_CTRL2) begin
      return c2;
    end else if (p == OLC_REG_STATUS) begin
      return {6'h00, c1[OLC_SRC_BIT], (lvl != OLC_LVL_OFF)};
    end else begin
      return 8'h00;
    end
  endfunction

  // ----------------------------------------------------------------------
  // State and bus events
  // ----------------------------------------------------------------------
  olc_state_t q;
  olc_state_t d;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_c;
  logic       stop_c;
  logic [7:0] rd_byte;

  // Next-state logic: pin filtering, serial slave and level selection.
  always_comb begin
    d = q;
    // Three-stage synchronisers; a change counts once stages two and three agree.
    // Edges come from the filtered clock pin, so both bus rates run one protocol;
    // the only limit is that each clock phase outlasts the filter delay.
    d.scl_s  = {q.scl_s[1:0], scl_in};
    d.sda_s  = {q.sda_s[1:0], sda_in};
    d.en_s   = {q.en_s[1:0], en_pin_in};
    d.step_s = {q.step_s[1:0], level_step_pin_in};
    d.asel_s = {q.asel_s[3:0], addr_sel_in};
    if (q.scl_s[1] == q.scl_s[2]) d.scl_f = q.scl_s[2];
    if (q.sda_s[1] == q.sda_s[2]) d.sda_f = q.sda_s[2];
    if (q.en_s[1] == q.en_s[2]) d.en_f = q.en_s[2];
    if (q.step_s[1] == q.step_s[2]) d.step_f = q.step_s[2];
    if (q.asel_s[3:2] == q.asel_s[5:4]) d.asel_f = q.asel_s[5:4];
    scl_rise = d.scl_f & ~q.scl_f;
    scl_fall = ~d.scl_f & q.scl_f;
    start_c  = q.scl_f & d.scl_f & q.sda_f & ~d.sda_f;
    stop_c   = q.scl_f & d.scl_f & ~q.sda_f & d.sda_f;
    rd_byte  = olc_read(q.ptr, q.ctrl1, q.ctrl2, q.level);
    if (start_c) begin
      // A start, first or repeated, always begins a new address byte.
      d.st     = OLC_ADDR;
      d.bitcnt = 4'h0;
      d.sda_oe = 1'b0;
    end else if (stop_c) begin
      d.st     = OLC_IDLE;
      d.sda_oe = 1'b0;
    end else if (scl_rise) begin
      case (q.st)
        OLC_ADDR, OLC_REG, OLC_WDATA: begin
          d.shift  = {q.shift[6:0], q.sda_f};
          d.bitcnt = 4'(q.bitcnt + 4'h1);
        end
        OLC_RDATA: begin
          d.bitcnt = 4'(q.bitcnt + 4'h1);
        end
        OLC_RDATA_ACK: begin
          if (q.sda_f) d.st = OLC_IDLE;
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      case (q.st)
        OLC_ADDR: begin
          if (q.bitcnt == OLC_BYTE_BITS) begin
            // Fixed 7-bit addresses never match general call or 10-bit headers.
            if (q.shift[7:1] == olc_slave_addr(q.asel_f)) begin
              d.sda_oe = 1'b1;
              d.rw     = q.shift[0];
              d.st     = OLC_ADDR_ACK;
            end else begin
              d.st = OLC_IDLE;
            end
          end
        end
        OLC_ADDR_ACK: begin
          d.bitcnt = 4'h0;
          if (q.rw) begin
            d.shift  = rd_byte;
            d.sda_oe = ~rd_byte[7];
            d.st     = OLC_RDATA;
          end else begin
            d.sda_oe = 1'b0;
            d.st     = OLC_REG;
          end
        end
        OLC_REG: begin
          if (q.bitcnt == OLC_BYTE_BITS) begin
            d.ptr    = q.shift;
            d.sda_oe = 1'b1;
            d.st     = OLC_REG_ACK;
          end
        end
        OLC_REG_ACK, OLC_WDATA_ACK: begin
          d.sda_oe = 1'b0;
          d.bitcnt = 4'h0;
          d.st     = OLC_WDATA;
        end
        OLC_WDATA: begin
          if (q.bitcnt == OLC_BYTE_BITS) begin
            // Writes are taken whatever the enable pin shows.
            if (q.ptr == OLC_REG_CTRL1) begin
              d.ctrl1 = q.shift;
            end else if (q.ptr == OLC_REG_CTRL2) begin
              d.ctrl2 = q.shift;
            end
            d.sda_oe = 1'b1;
            d.st     = OLC_WDATA_ACK;
          end
        end
        OLC_RDATA: begin
          if (q.bitcnt == OLC_BYTE_BITS) begin
            d.sda_oe = 1'b0;
            d.bitcnt = 4'h0;
            d.st     = OLC_RDATA_ACK;
          end else begin
            d.shift  = {q.shift[6:0], 1'b0};
            d.sda_oe = ~q.shift[6];
          end
        end
        OLC_RDATA_ACK: begin
          d.shift  = rd_byte;
          d.sda_oe = ~rd_byte[7];
          d.st     = OLC_RDATA;
        end
        default: begin
        end
      endcase
    end
    // Level follows the source chosen by the source-select bit.
    d.level = olc_level(q.ctrl1[OLC_SRC_BIT], q.ctrl2[OLC_EN_BIT], q.en_f, q.scl_f,
                        q.step_f, q.ctrl1[OLC_CODE_MSB:OLC_CODE_LSB]);
  end

  // State register.
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      q <= OLC_STATE_RST;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state; the data pin is only ever pulled low.
  assign sda_out                    = 1'b0;
  assign sda_oe_out                 = q.sda_oe;
  assign regulated_output_level_out = q.level;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  a_pin_off_level: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (!q.ctrl1[OLC_SRC_BIT] && !q.en_f) |=> (q.level == OLC_LVL_OFF))
    else $error("Pin mode with enable low did not give zero level.");
  a_pin_high_level: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (!q.ctrl1[OLC_SRC_BIT] && q.en_f && q.scl_f && q.step_f) |=> (q.level == OLC_LVL_194))
    else $error("Pin mode high high did not give 19.4 V.");
  a_reg_ignores_en: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (q.ctrl1[OLC_SRC_BIT] && q.ctrl2[OLC_EN_BIT] && !q.en_f &&
     q.ctrl1[OLC_CODE_MSB:OLC_CODE_LSB] == 4'h4) |=> (q.level == OLC_LVL_134))
    else $error("Register mode level did not follow the voltage code.");
  a_reg_en_gate: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (q.ctrl1[OLC_SRC_BIT] && !q.ctrl2[OLC_EN_BIT]) |=> (q.level == OLC_LVL_OFF))
    else $error("Register mode with enable bit clear did not give zero level.");
  a_addr_mismatch: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (q.st == OLC_ADDR && scl_fall && q.bitcnt == OLC_BYTE_BITS &&
     q.shift[7:1] != olc_slave_addr(q.asel_f)) |=> (!q.sda_oe && q.st == OLC_IDLE))
    else $error("Foreign address was acknowledged.");
  a_ack_held: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    ((q.st == OLC_ADDR_ACK || q.st == OLC_REG_ACK || q.st == OLC_WDATA_ACK) &&
     scl_rise) |-> q.sda_oe)
    else $error("Acknowledge not held low during clock high.");
  a_write_commit: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (q.st == OLC_WDATA && scl_fall && q.bitcnt == OLC_BYTE_BITS && q.ptr == OLC_REG_CTRL1)
    |=> (q.ctrl1 == $past(q.shift)))
    else $error("Data byte not committed on last falling edge.");
  a_stop_release: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    stop_c |=> (!q.sda_oe && q.st == OLC_IDLE))
    else $error("Data line still pulled after stop.");
  a_start_addr: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    start_c |=> (q.st == OLC_ADDR && q.bitcnt == 4'h0))
    else $error("Start did not begin an address byte.");

  // Properties sample the registered state; all but a_ack_held, a_read_bit and a_idle_release check their consequent one clock later.
  a_pin_mid_level: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (!q.ctrl1[OLC_SRC_BIT] && q.en_f && !(q.scl_f && q.step_f)) |=>
    (q.level == ($past(q.scl_f) ? OLC_LVL_146 :
                 ($past(q.step_f) ? OLC_LVL_182 : OLC_LVL_134))))
    else $error("Pin mode level did not follow the clock and step pins.");
  a_ptr_load: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (q.st == OLC_REG && scl_fall && q.bitcnt == OLC_BYTE_BITS) |=>
    (q.ptr == $past(q.shift) && q.sda_oe && q.st == OLC_REG_ACK))
    else $error("Register address byte was not taken and acknowledged.");
  a_ctrl2_commit: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (q.st == OLC_WDATA && scl_fall && q.bitcnt == OLC_BYTE_BITS && q.ptr == OLC_REG_CTRL2)
    |=> (q.ctrl2 == $past(q.shift) && q.sda_oe))
    else $error("Second control byte not committed on last falling edge.");
  a_addr_ack: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (q.st == OLC_ADDR && scl_fall && q.bitcnt == OLC_BYTE_BITS &&
     q.shift[7:1] == olc_slave_addr(q.asel_f)) |=> (q.sda_oe && q.st == OLC_ADDR_ACK))
    else $error("Own address was not acknowledged.");
  a_read_bit: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (q.st == OLC_RDATA) |-> (q.sda_oe != q.shift[7]))
    else $error("Read bit on the data line does not match the shifted byte.");
  a_nack_idle: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (q.st == OLC_RDATA_ACK && scl_rise && q.sda_f) |=> (q.st == OLC_IDLE && !q.sda_oe))
    else $error("Read byte without acknowledge did not end the transfer.");
  a_idle_release: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (q.st == OLC_IDLE) |-> !q.sda_oe)
    else $error("Data line pulled while the slave is idle.");

endmodule

// >>> tb/olc_bus_master.sv
// Behavioural two-wire bus master that drives the slave from the far side.
module olc_bus_master (
  // Clock and bus wire level.
  input  wire logic sys_clk_in,
  input  wire logic sda_in,
  // Master clock and open-drain data pull.
  output logic      scl_out,
  output logic      sda_low_out
);
  timeunit 1ns;
  timeprecision 100ps;

  // Clocks per bus clock phase, well above the slave's filter delay; t_rate changes it.
  int half;

  // The bus rests idle with both lines released.
  initial begin
    half = 16;
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end

  // Waits some clocks, then steps just past the edge.
  task automatic t_wait(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask

  // Sets the clocks per bus clock phase, so one bench runs several bus rates.
  task automatic t_rate(input int n);
    half = n;
  endtask

  // Sets the clock line directly while the data line stays put.
  task automatic t_scl(input logic v);
    scl_out = v;
  endtask

  // Clocks one bit and samples the wire late in the high phase.
  task automatic t_bit(input logic b, output logic r);
    t_wait(4);
    sda_low_out = ~b;
    t_wait(half);
    scl_out = 1'b1;
    t_wait(half);
    r = sda_in;
    scl_out = 1'b0;
  endtask

  // Start or repeated start: data falls while the clock is high.
  task automatic t_start();
    t_wait(4);
    sda_low_out = 1'b0;
    t_wait(half);
    scl_out = 1'b1;
    t_wait(half);
    sda_low_out = 1'b1;
    t_wait(half);
    scl_out = 1'b0;
  endtask

  // Stop: data rises while the clock is high.
  task automatic t_stop();
    t_wait(4);
    sda_low_out = 1'b1;
    t_wait(half);
    scl_out = 1'b1;
    t_wait(half);
    sda_low_out = 1'b0;
    t_wait(half);
  endtask

  // One byte MSB first, then a released ninth bit; a read byte is never acknowledged.
  task automatic t_byte(input logic [7:0] d, output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      t_bit(d[i], q[i]);
    end
    t_bit(1'b1, r);
    ack = ~r;
  endtask

  // Single register write: address, register byte, data byte.
  task automatic t_write(input logic [6:0] a, input logic [7:0] r, input logic [7:0] d,
                         output logic [2:0] ok);
    logic [7:0] q;
    t_start();
    t_byte({a, 1'b0}, q, ok[2]);
    t_byte(r, q, ok[1]);
    t_byte(d, q, ok[0]);
    t_stop();
  endtask

  // Register read through a repeated start.
  task automatic t_read(input logic [6:0] a, input logic [7:0] r, output logic [7:0] d,
                        output logic [2:0] ok);
    logic [7:0] q;
    logic       n;
    t_start();
    t_byte({a, 1'b0}, q, ok[2]);
    t_byte(r, q, ok[1]);
    t_start();
    t_byte({a, 1'b1}, q, ok[0]);
    t_byte(8'hff, d, n);
    t_stop();
  endtask
endmodule

// >>> tb/tb_olc_top.sv
// Self-checking bench of the output level control block.
module tb_olc_top
  import olc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // Pin mode row: enable, clock and step pins beside the expected level.
  typedef struct packed {
    logic       en;
    logic       scl;
    logic       step;
    logic [7:0] lvl;
  } olc_row_t;

  localparam olc_row_t ROWS [6] = '{
    '{1'b1, 1'b1, 1'b1, OLC_LVL_194}, '{1'b1, 1'b1, 1'b0, OLC_LVL_146},
    '{1'b1, 1'b0, 1'b1, OLC_LVL_182}, '{1'b1, 1'b0, 1'b0, OLC_LVL_134},
    '{1'b0, 1'b1, 1'b1, OLC_LVL_OFF}, '{1'b0, 1'b0, 1'b0, OLC_LVL_OFF}};
  localparam logic [6:0] ADR [4] = '{OLC_ADDR_VCC, OLC_ADDR_FLOAT, OLC_ADDR_GND, OLC_ADDR_DIV};

  logic       clk = 1'b0;
  logic       rst;
  logic       en;
  logic       step;
  logic [1:0] asel;
  logic       scl;
  logic       sda_low;
  logic       sda_dev;
  logic       sda_oe;
  logic [7:0] level;
  logic [7:0] d;
  logic [2:0] ok;
  int         failures = 0;
  int         n_tests = 0;
  wire        sda = ~(sda_oe | sda_low);

  // Clock of 8 ns period.
  always #4 clk = ~clk;

  olc_top i_dut (
    .sys_clk_in(clk), .rst_in(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_dev),
    .sda_oe_out(sda_oe), .en_pin_in(en), .level_step_pin_in(step), .addr_sel_in(asel),
    .regulated_output_level_out(level));

  olc_bus_master i_mst (.sys_clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_low_out(sda_low));

  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // Level expected from a voltage code in register mode.
  function automatic logic [7:0] lvl_of(input int c);
    if (c <= 12) begin
      return 8'h6e + 8'(6 * c);
    end
    return (c == 13) ? 8'hc2 : 8'hc8;
  endfunction

  // Prints the verdict and ends the run.
  task automatic end_sim();
    if (failures == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Cuts a hang short, well past the expected run of about 450 us.
  initial begin
    #600us;
    failures++;
    end_sim();
  end

  // Main sequence.
  initial begin
    rst = 1'b1;
    en = 1'b0;
    step = 1'b0;
    asel = 2'h0;
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    i_mst.t_wait(8);
    chk(level, OLC_LVL_OFF);
    i_mst.t_read(OLC_ADDR_VCC, OLC_REG_CTRL1, d, ok);
    chk(d, OLC_CTRL1_RST);
    chk({5'h0, ok}, 8'h07);
    i_mst.t_read(OLC_ADDR_VCC, OLC_REG_CTRL2, d, ok);
    chk(d, OLC_CTRL2_RST);
    // Pin mode table, the bus clock line standing in for the clock pin.
    foreach (ROWS[i]) begin
      en = ROWS[i].en;
      step = ROWS[i].step;
      i_mst.t_scl(ROWS[i].scl);
      i_mst.t_wait(10);
      chk(level, ROWS[i].lvl);
    end
    i_mst.t_scl(1'b1);
    // Each address pin state answers at its own address and ignores another.
    for (int a = 0; a < 4; a++) begin
      asel = 2'(a);
      i_mst.t_wait(10);
      i_mst.t_write(ADR[a], OLC_REG_CTRL1, 8'h20 + 8'(a), ok);
      chk({5'h0, ok}, 8'h07);
      i_mst.t_write(ADR[(a + 1) % 4], OLC_REG_CTRL1, 8'h5a, ok);
      chk({5'h0, ok}, 8'h00);
      i_mst.t_read(ADR[a], OLC_REG_CTRL1, d, ok);
      chk(d, 8'h20 + 8'(a));
    end
    i_mst.t_write(7'h00, OLC_REG_CTRL1, 8'h5a, ok);
    chk({5'h0, ok}, 8'h00);
    i_mst.t_write(7'h78, OLC_REG_CTRL1, 8'h5a, ok);
    chk({5'h0, ok}, 8'h00);
    // Register mode with the enable pin low: every voltage code.
    asel = 2'h0;
    en = 1'b0;
    i_mst.t_wait(10);
    for (int c = 0; c < 16; c++) begin
      i_mst.t_write(OLC_ADDR_VCC, OLC_REG_CTRL1, {1'b1, 2'b00, 4'(c), 1'b0}, ok);
      i_mst.t_wait(4);
      chk(level, lvl_of(c));
    end
    // The enable bit gates the register mode level.
    i_mst.t_write(OLC_ADDR_VCC, OLC_REG_CTRL2, 8'h01, ok);
    i_mst.t_wait(4);
    chk(level, OLC_LVL_OFF);
    i_mst.t_write(OLC_ADDR_VCC, OLC_REG_CTRL2, 8'h09, ok);
    i_mst.t_wait(4);
    chk(level, OLC_LVL_200);
    chk({7'h0, sda_dev}, 8'h00);
    // A fast-rate write runs the same protocol at about 400 kHz.
    i_mst.t_rate(156);
    i_mst.t_write(OLC_ADDR_VCC, OLC_REG_CTRL1, 8'h9a, ok);
    i_mst.t_rate(16);
    chk({5'h0, ok}, 8'h07);
    i_mst.t_wait(4);
    chk(level, OLC_LVL_194);
    // The status offset is read only and unmapped offsets read zero.
    i_mst.t_write(OLC_ADDR_VCC, OLC_REG_STATUS, 8'h00, ok);
    chk({5'h0, ok}, 8'h07);
    i_mst.t_read(OLC_ADDR_VCC, OLC_REG_STATUS, d, ok);
    chk(d, 8'h03);
    i_mst.t_read(OLC_ADDR_VCC, 8'h05, d, ok);
    chk(d, 8'h00);
    // Reset in mid-run restores the reset image.
    rst = 1'b1;
    i_mst.t_wait(2);
    rst = 1'b0;
    i_mst.t_wait(8);
    chk(level, OLC_LVL_OFF);
    i_mst.t_read(OLC_ADDR_VCC, OLC_REG_CTRL1, d, ok);
    chk(d, OLC_CTRL1_RST);
    i_mst.t_read(OLC_ADDR_VCC, OLC_REG_CTRL2, d, ok);
    chk(d, OLC_CTRL2_RST);
    end_sim();
  end
endmodule
